// [logic/shch_fifo.sv]
// Parameterised first-word-fall-through FIFO for record characters
`default_nettype none
module shch_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic flush,
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  // Storage array
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;
  logic doWrite;
  logic doRead;

  // Full and empty come straight from the occupancy count
  assign inReady = (level != (AW+1)'(DEPTH));
  assign outValid = (level != '0);
  assign outData = mem[rdPtr];
  assign doWrite = inValid && inReady;
  assign doRead = outValid && outReady;

  // Write side
  always_ff @(posedge clk) begin
    if (doWrite) begin
      mem[wrPtr] <= inData;
    end
  end

  // Pointers and level; flush empties at once
  always_ff @(posedge clk) begin
    if (sys_rst || flush) begin
      wrPtr <= '0;
      rdPtr <= '0;
      level <= '0;
    end else begin
      if (doWrite) begin
        wrPtr <= wrPtr + 1'b1;
      end
      if (doRead) begin
        rdPtr <= rdPtr + 1'b1;
      end
      level <= level + (AW+1)'(doWrite) - (AW+1)'(doRead);
    end
  end
endmodule : shch_fifo
`default_nettype wire

// [logic/shch_handler.sv]
// Top of the serial host command handler: decode, selection, replies
`default_nettype none
module shch_handler #(
  parameter int BIT_CYCLES = shch_pkg::BIT_CYCLES,
  parameter int FIFO_DEPTH = shch_pkg::FIFO_DEPTH,
  // Arbitrary neutral identity values
  parameter logic [31:0] MODEL_ID = 32'h4D4F4431,
  parameter logic [47:0] FW_ID = 48'h465730303141
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic rxPin,
  output logic txPin,
  input wire logic [5:0] locationNumber,
  input wire logic [7:0] recData,
  input wire logic recValid,
  output logic recReady,
  input wire logic cycleDone,
  input wire logic holding,
  output logic autoMode,
  output logic countRun,
  output logic countTimed,
  output logic pumpOn,
  output logic sensorOn,
  output logic offLine,
  output logic selected,
  output logic universal
);
  localparam int LW = $clog2(FIFO_DEPTH) + 1;
  logic [7:0] rxData;
  logic rxStrobe;
  logic [7:0] txData;
  logic txValid;
  logic txReady;
  logic [7:0] fifoData;
  logic fifoValid;
  logic fifoReady;
  logic [LW-1:0] fifoLevel;
  logic fifoFlush;
  logic anyDone;
  logic [7:0] recLen;
  logic [7:0] lastRec [FIFO_DEPTH];
  logic [7:0] lastLen;
  logic [7:0] idx;
  logic [7:0] replyChar;
  logic [7:0] countVal;
  logic isSelect;
  logic listening;
  shch_pkg::shch_src_e src;
  logic romModel; // Set while the model string is walked, clear for firmware
  logic univLocked; // A select code was seen; 'U' stays dead until reset

  // Byte in the 128..191 select window
  function automatic logic sel_code(input logic [7:0] b);
    sel_code = (b[shch_pkg::SEL_TOP_MSB:shch_pkg::SEL_TOP_LSB] == shch_pkg::SEL_TOP);
  endfunction : sel_code

  // Decimal digit to ASCII
  function automatic logic [7:0] dig(input logic [7:0] v);
    dig = shch_pkg::CH_ZERO + v;
  endfunction : dig

  shch_uart #(
    .BIT_CYCLES(BIT_CYCLES)
  ) uUart (
    .clk(clk),
    .sys_rst(sys_rst),
    .rxPin(rxPin),
    .txPin(txPin),
    .rxData(rxData),
    .rxStrobe(rxStrobe),
    .txData(txData),
    .txValid(txValid),
    .txReady(txReady)
  );

  // Record characters wait here until a host asks for them
  shch_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) uFifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .flush(fifoFlush),
    .inData(recData),
    .inValid(recValid),
    .inReady(recReady),
    .outData(fifoData),
    .outValid(fifoValid),
    .outReady(fifoReady),
    .level(fifoLevel)
  );

  assign isSelect = rxStrobe && sel_code(rxData);
  assign listening = rxStrobe && !isSelect && (selected || universal) && !offLine
    && src == shch_pkg::SHCH_SRC_NONE;

  // cleared by any select, rearmed only by reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      universal <= 1'b0;
      univLocked <= 1'b0;
    end else if (isSelect) begin
      // Any select code disarms 'U' until the next reset
      universal <= 1'b0;
      univLocked <= 1'b1;
    end else if (rxStrobe && rxData == shch_pkg::CMD_UNIVERSAL && !univLocked && !offLine) begin
      // Still armed: taken whether this device is addressed or not
      universal <= 1'b1;
    end
  end

  // match value minus 128 to location
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      selected <= 1'b0;
    end else if (isSelect) begin
      selected <= (rxData[5:0] == locationNumber);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      autoMode <= 1'b0;
    end else if (listening && rxData == shch_pkg::CMD_AUTO) begin
      autoMode <= 1'b1;
    end else if (listening && rxData == shch_pkg::CMD_MANUAL) begin
      autoMode <= 1'b0;
    end
  end

  // Counting control; the cycle timer outside ends timed runs
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      countRun <= 1'b0;
      countTimed <= 1'b0;
    end else if (listening && rxData == shch_pkg::CMD_START_HOST) begin
      countRun <= 1'b1;
      countTimed <= 1'b0;
    end else if (listening && rxData == shch_pkg::CMD_START_TIMED) begin
      countRun <= 1'b1;
      countTimed <= 1'b1;
    end else if (listening && rxData == shch_pkg::CMD_STOP) begin
      countRun <= 1'b0;
      countTimed <= 1'b0;
    end else if (cycleDone && countTimed) begin
      countRun <= 1'b0;
      countTimed <= 1'b0;
    end
  end

  // Power and line state
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pumpOn <= 1'b1;
      sensorOn <= 1'b1;
      offLine <= 1'b0;
    end else if (listening && rxData == shch_pkg::CMD_STANDBY) begin
      // standby powers down pump and sensor
      pumpOn <= 1'b0;
      sensorOn <= 1'b0;
    end else if (listening && rxData == shch_pkg::CMD_ACTIVE) begin
      pumpOn <= 1'b1;
      sensorOn <= 1'b1;
    end else if (listening && rxData == shch_pkg::CMD_LOCAL) begin
      offLine <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      anyDone <= 1'b0;
    end else if (cycleDone) begin
      anyDone <= 1'b1;
    end
  end

  // Records delimited by cycleDone; count them with a bound
  always_ff @(posedge clk) begin
    if (sys_rst || fifoFlush) begin
      recLen <= '0;
    end else if (cycleDone) begin
      recLen <= 8'(fifoLevel);
    end else if (src == shch_pkg::SHCH_SRC_RECORD && fifoValid && txReady
      && idx + 8'h01 == recLen) begin
      // A fully sent record no longer counts as buffered
      recLen <= '0;
    end
  end

  assign fifoFlush = listening && rxData == shch_pkg::CMD_CLEAR;

  // Reply sequencer: one character at a time into the transmitter
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      src <= shch_pkg::SHCH_SRC_NONE;
      idx <= '0;
      replyChar <= '0;
      countVal <= '0;
      romModel <= 1'b0;
    end else if (src == shch_pkg::SHCH_SRC_NONE) begin
      idx <= '0;
      if (listening) begin
        case (rxData)
          shch_pkg::CMD_MODE: begin
            src <= shch_pkg::SHCH_SRC_CHAR;
            replyChar <= countRun ? (holding ? shch_pkg::CH_HOLDING : shch_pkg::CH_COUNTING)
              : shch_pkg::CH_STOPPED;
          end
          shch_pkg::CMD_COUNT: begin
            // buffered record count as two digits, only ever 00 or 01
            src <= shch_pkg::SHCH_SRC_COUNT;
            countVal <= (anyDone && recLen != '0) ? 8'h01 : 8'h00;
          end
          shch_pkg::CMD_FWREV: begin
            src <= shch_pkg::SHCH_SRC_ROM;
            idx <= 8'h06;
            romModel <= 1'b0;
          end
          shch_pkg::CMD_MODEL: begin
            src <= shch_pkg::SHCH_SRC_ROM;
            idx <= 8'h04;
            romModel <= 1'b1;
          end
          shch_pkg::CMD_SEND: begin
            // none while counting or before first cycle
            if (anyDone && !countRun && recLen != '0 && fifoValid) begin
              src <= shch_pkg::SHCH_SRC_RECORD;
            end else begin
              src <= shch_pkg::SHCH_SRC_CHAR;
              replyChar <= shch_pkg::CH_EMPTY;
            end
          end
          shch_pkg::CMD_RESEND: begin
            // only the latest record is kept
            if (lastLen != '0) begin
              src <= shch_pkg::SHCH_SRC_RESEND;
            end else begin
              src <= shch_pkg::SHCH_SRC_CHAR;
              replyChar <= shch_pkg::CH_EMPTY;
            end
          end
          default: begin
            src <= shch_pkg::SHCH_SRC_NONE;
          end
        endcase
      end
    end else if (txValid && txReady) begin
      case (src)
        shch_pkg::SHCH_SRC_CHAR: begin
          src <= shch_pkg::SHCH_SRC_NONE;
        end
        shch_pkg::SHCH_SRC_COUNT: begin
          idx <= idx + 8'h01;
          if (idx == 8'h01) begin
            src <= shch_pkg::SHCH_SRC_NONE;
          end
        end
        shch_pkg::SHCH_SRC_ROM: begin
          idx <= idx - 8'h01;
          if (idx == 8'h01) begin
            src <= shch_pkg::SHCH_SRC_NONE;
          end
        end
        shch_pkg::SHCH_SRC_RECORD: begin
          idx <= idx + 8'h01;
          if (idx + 8'h01 == recLen) begin
            src <= shch_pkg::SHCH_SRC_NONE;
          end
        end
        shch_pkg::SHCH_SRC_RESEND: begin
          idx <= idx + 8'h01;
          if (idx + 8'h01 == lastLen) begin
            src <= shch_pkg::SHCH_SRC_NONE;
          end
        end
        default: begin
          src <= shch_pkg::SHCH_SRC_NONE;
        end
      endcase
    end
  end

  // record bytes pass through in stored order
  assign fifoReady = (src == shch_pkg::SHCH_SRC_RECORD) && txReady;

  // Copy of the record being sent, kept for resend
  always_ff @(posedge clk) begin
    if (src == shch_pkg::SHCH_SRC_RECORD && txReady && fifoValid) begin
      lastRec[idx[$clog2(FIFO_DEPTH)-1:0]] <= fifoData;
    end
  end

  // Length of the last record sent
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lastLen <= '0;
    end else if (src == shch_pkg::SHCH_SRC_RECORD && txReady && idx + 8'h01 == recLen) begin
      lastLen <= recLen;
    end
  end

  // Character presented to the transmitter
  always_comb begin
    txValid = 1'b0;
    txData = '0;
    case (src)
      shch_pkg::SHCH_SRC_CHAR: begin
        txValid = 1'b1;
        txData = replyChar;
      end
      shch_pkg::SHCH_SRC_COUNT: begin
        txValid = 1'b1;
        txData = (idx == '0) ? shch_pkg::CH_ZERO : dig(countVal);
      end
      shch_pkg::SHCH_SRC_ROM: begin
        txValid = 1'b1;
        // The decode remembers which string is being walked
        txData = romModel ? MODEL_ID[8*idx-1 -: 8] : FW_ID[8*idx-1 -: 8];
      end
      shch_pkg::SHCH_SRC_RECORD: begin
        txValid = fifoValid;
        txData = fifoData;
      end
      shch_pkg::SHCH_SRC_RESEND: begin
        txValid = 1'b1;
        txData = lastRec[idx[$clog2(FIFO_DEPTH)-1:0]];
      end
      default: begin
        txValid = 1'b0;
      end
    endcase
  end
endmodule : shch_handler
`default_nettype wire

// [logic/shch_pkg.sv]
// Constants and types shared by the serial host command handler
// Contract
// - Frame is 8 data, 1 stop, no parity
// - 'a' sets auto, 'b' manual mode
// - 'c' starts host-timed counting immediately
// - 'd' starts counting timed by sample period
// - 'e' stops counting immediately
// - 'C' erases all buffered records
// - 'D' sends buffered record count; the code only ever reports 00 or 01
// - 'E' sends firmware part and revision
// - 'M' replies C, H or S state
// - 'T' sends four-character model identifier
// - 'A' sends and removes record, else '#'
// - No finished cycle or counting gives '#'
// - 'R' resends last sent record
// - 'h' standby: pump off, sensor off
// - 'g' active: pump on for purge
// - 'l' goes off-line, factory test only
// - 'U' answers regardless of select code
// - Select 128-191 cancels universal for good
// - Select value minus 128 is location number
// - Other select value deselects this device
// - Records are tagged ASCII data strings
`default_nettype none
package shch_pkg;
  // Command characters
  localparam logic [7:0] CMD_AUTO = 8'h61;
  localparam logic [7:0] CMD_MANUAL = 8'h62;
  localparam logic [7:0] CMD_START_HOST = 8'h63;
  localparam logic [7:0] CMD_START_TIMED = 8'h64;
  localparam logic [7:0] CMD_STOP = 8'h65;
  localparam logic [7:0] CMD_CLEAR = 8'h43;
  localparam logic [7:0] CMD_COUNT = 8'h44;
  localparam logic [7:0] CMD_FWREV = 8'h45;
  localparam logic [7:0] CMD_MODE = 8'h4D;
  localparam logic [7:0] CMD_MODEL = 8'h54;
  localparam logic [7:0] CMD_SEND = 8'h41;
  localparam logic [7:0] CMD_RESEND = 8'h52;
  localparam logic [7:0] CMD_STANDBY = 8'h68;
  localparam logic [7:0] CMD_ACTIVE = 8'h67;
  localparam logic [7:0] CMD_LOCAL = 8'h6C;
  localparam logic [7:0] CMD_UNIVERSAL = 8'h55;
  // Reply characters
  localparam logic [7:0] CH_COUNTING = 8'h43;
  localparam logic [7:0] CH_HOLDING = 8'h48;
  localparam logic [7:0] CH_STOPPED = 8'h53;
  localparam logic [7:0] CH_EMPTY = 8'h23;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_CR = 8'h0D;
  // Select range 128..191
  localparam logic [1:0] SEL_TOP = 2'h2;
  localparam int SEL_TOP_MSB = 7;
  localparam int SEL_TOP_LSB = 6;
  // Serial timing
  localparam int CLK_HZ = 40000000;
  localparam int BAUD = 9600;
  localparam int BIT_CYCLES = CLK_HZ / BAUD;
  localparam int DATA_BITS = 8;
  localparam int STOP_BITS = 1;
  // Record geometry: three-char tag then six data chars
  localparam int TAG_CHARS = 3;
  localparam int ITEM_CHARS = 6;
  localparam int FIFO_DEPTH = 32;
  // Reply sources
  typedef enum logic [2:0] {
    SHCH_SRC_NONE = 3'b000,
    SHCH_SRC_CHAR = 3'b001,
    SHCH_SRC_COUNT = 3'b010,
    SHCH_SRC_ROM = 3'b011,
    SHCH_SRC_RECORD = 3'b100,
    SHCH_SRC_RESEND = 3'b101
  } shch_src_e;
endpackage : shch_pkg
`default_nettype wire

// [logic/shch_uart.sv]
// Fixed 8N1 serial receiver and transmitter
`default_nettype none
module shch_uart #(
  parameter int BIT_CYCLES = shch_pkg::BIT_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic rxPin,
  output logic txPin,
  output logic [7:0] rxData,
  output logic rxStrobe,
  input wire logic [7:0] txData,
  input wire logic txValid,
  output logic txReady
);
  localparam int CW = $clog2(BIT_CYCLES + 1);
  localparam logic [CW-1:0] BIT_LAST = CW'(BIT_CYCLES - 1);
  localparam logic [CW-1:0] HALF_BIT = CW'(BIT_CYCLES / 2);
  // Frame is start, 8 data, 1 stop: ten slots
  localparam logic [3:0] FRAME_SLOTS = 4'(shch_pkg::DATA_BITS + shch_pkg::STOP_BITS + 1);
  logic rxMeta;
  logic rxSync;
  logic rxBusy;
  logic [CW-1:0] rxTimer;
  logic [3:0] rxSlot;
  logic [7:0] rxShift;
  logic txBusy;
  logic [CW-1:0] txTimer;
  logic [3:0] txSlot;
  logic [9:0] txShift;

  // Two-stage synchroniser on the pin
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rxMeta <= 1'b1;
      rxSync <= 1'b1;
    end else begin
      rxMeta <= rxPin;
      rxSync <= rxMeta;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rxBusy <= 1'b0;
      rxTimer <= '0;
      rxSlot <= '0;
      rxShift <= '0;
      rxData <= '0;
      rxStrobe <= 1'b0;
    end else begin
      rxStrobe <= 1'b0;
      if (!rxBusy) begin
        // Wait for a start edge, sample mid-bit afterwards
        if (!rxSync) begin
          rxBusy <= 1'b1;
          rxTimer <= HALF_BIT;
          rxSlot <= '0;
        end
      end else if (rxTimer != '0) begin
        rxTimer <= rxTimer - 1'b1;
      end else begin
        rxTimer <= BIT_LAST;
        rxSlot <= rxSlot + 1'b1;
        if (rxSlot == '0 && rxSync) begin
          // False start: glitch shorter than half a bit
          rxBusy <= 1'b0;
        end else if (rxSlot == FRAME_SLOTS - 4'h1) begin
          // Stop slot: a framing error drops the byte
          rxBusy <= 1'b0;
          if (rxSync) begin
            rxData <= rxShift;
            rxStrobe <= 1'b1;
          end
        end else if (rxSlot != '0) begin
          rxShift <= {rxSync, rxShift[7:1]};
        end
      end
    end
  end

  assign txReady = !txBusy;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      txBusy <= 1'b0;
      txTimer <= '0;
      txSlot <= '0;
      txShift <= '1;
      txPin <= 1'b1;
    end else if (!txBusy) begin
      txPin <= 1'b1;
      if (txValid) begin
        txBusy <= 1'b1;
        txShift <= {1'b1, txData, 1'b0};
        txTimer <= BIT_LAST;
        txSlot <= '0;
        txPin <= 1'b0;
      end
    end else if (txTimer != '0) begin
      txTimer <= txTimer - 1'b1;
    end else begin
      txTimer <= BIT_LAST;
      txSlot <= txSlot + 1'b1;
      if (txSlot == FRAME_SLOTS - 4'h1) begin
        txBusy <= 1'b0;
        txPin <= 1'b1;
      end else begin
        txPin <= txShift[txSlot + 4'h1];
      end
    end
  end
endmodule : shch_uart
`default_nettype wire

// [test/shch_handler_props.sv]
// Pin-level checks on the serial host command handler
`default_nettype none
module shch_handler_props #(
  parameter int BIT_CYCLES = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic rxPin,
  input wire logic txPin,
  input wire logic [5:0] locationNumber,
  input wire logic [7:0] recData,
  input wire logic recValid,
  input wire logic recReady,
  input wire logic cycleDone,
  input wire logic holding,
  input wire logic autoMode,
  input wire logic countRun,
  input wire logic countTimed,
  input wire logic pumpOn,
  input wire logic sensorOn,
  input wire logic offLine,
  input wire logic selected,
  input wire logic universal
);
  // Frame geometry in clocks
  localparam int IDLE_MIN = 8 * BIT_CYCLES;
  localparam int START_END = BIT_CYCLES - 1;
  localparam int STOP_AT = 9 * BIT_CYCLES;
  int idleCnt; // Run of high samples on the reply line
  logic cancelled; // Universal selection was dropped once
  logic startFall; // A fall that can only be a start bit
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // No frame holds eight high bits before a fall, so this is a start
  assign startFall = !txPin && (idleCnt == IDLE_MIN);
  // Saturating idle counter
  always_ff @(posedge clk) begin
    if (sys_rst || !txPin) begin
      idleCnt <= 0;
    end else if (idleCnt < IDLE_MIN) begin
      idleCnt <= idleCnt + 1;
    end
  end
  // Remember a cancel; a reset edge is not one
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cancelled <= 1'b0;
    end else if ($fell(universal) && !$past(sys_rst)) begin
      cancelled <= 1'b1;
    end
  end
  sequence s_start_bit;
    !txPin ##START_END !txPin;
  endsequence
  sequence s_stop_bit;
    ##STOP_AT txPin;
  endsequence
  property p_rst_state;
    $fell(sys_rst) |-> txPin && recReady && !autoMode && !countRun && pumpOn && sensorOn
      && !offLine && !selected && !universal;
  endproperty
  property p_frame_start;
    startFall |-> s_start_bit;
  endproperty
  property p_frame_stop;
    startFall |-> s_stop_bit;
  endproperty
  property p_standby_pair;
    pumpOn == sensorOn;
  endproperty
  property p_univ_once;
    cancelled |-> !universal;
  endproperty
  property p_unsel_quiet;
    !selected && !universal |-> !startFall;
  endproperty
  property p_offline_quiet;
    offLine |-> !startFall;
  endproperty
  property p_timed_run;
    $rose(countTimed) |-> ##[0:2] countRun;
  endproperty
  a_rst_state: assert property (p_rst_state) else $error("bad levels after reset");
  a_frame_start: assert property (p_frame_start) else $error("start bit short");
  a_frame_stop: assert property (p_frame_stop) else $error("stop bit missing");
  a_standby_pair: assert property (p_standby_pair) else $error("pump and sensor split");
  a_univ_once: assert property (p_univ_once) else $error("universal re-armed");
  a_unsel_quiet: assert property (p_unsel_quiet) else $error("reply while unselected");
  a_offline_quiet: assert property (p_offline_quiet) else $error("reply while offline");
  a_timed_run: assert property (p_timed_run) else $error("timed without run");
endmodule : shch_handler_props
bind shch_handler shch_handler_props #(.BIT_CYCLES(BIT_CYCLES)) u_props (
  .clk(clk), .sys_rst(sys_rst), .rxPin(rxPin), .txPin(txPin),
  .locationNumber(locationNumber), .recData(recData), .recValid(recValid),
  .recReady(recReady), .cycleDone(cycleDone), .holding(holding), .autoMode(autoMode),
  .countRun(countRun), .countTimed(countTimed), .pumpOn(pumpOn), .sensorOn(sensorOn),
  .offLine(offLine), .selected(selected), .universal(universal)
);
`default_nettype wire

// [test/shch_handler_tb.sv]
// Self-checking bench for the serial host command handler
`default_nettype none
module shch_handler_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BITC = 8; // Short bit time keeps the run brief
  localparam logic [31:0] MODEL = 32'h5A513032; // Arbitrary value
  localparam logic [47:0] FW = 48'h465741423032; // Arbitrary value
  typedef struct {logic [7:0] c; int n; logic [31:0] r; logic [2:0] lv;} shch_row_s;
  logic clk, sysRst, rxPin, txPin, recValid, recReady, cycleDone, holding;
  logic autoMode, countRun, countTimed, pumpOn, sensorOn, offLine, selected, universal;
  logic [7:0] recData;
  int errCount, cmpCount;
  logic [7:0] rx[$]; // Reply bytes of the last command
  // Command, reply length, reply, {autoMode, countRun, pumpOn}
  shch_row_s rows[14] = '{
    '{8'h61, 0, 0, 3'b101}, '{8'h62, 0, 0, 3'b001}, '{8'h4D, 1, 32'h53, 3'b001},
    '{8'h54, 4, MODEL, 3'b001}, '{8'h41, 1, 32'h23, 3'b001}, '{8'h52, 1, 32'h23, 3'b001},
    '{8'h44, 2, 32'h3030, 3'b001}, '{8'h68, 0, 0, 3'b000}, '{8'h67, 0, 0, 3'b001},
    '{8'h63, 0, 0, 3'b011}, '{8'h4D, 1, 32'h43, 3'b011}, '{8'h65, 0, 0, 3'b001},
    '{8'h64, 0, 0, 3'b011}, '{8'h65, 0, 0, 3'b001}};
  shch_host_model #(.BIT_CYCLES(BITC)) u_host (.clk(clk), .rxLine(rxPin), .txLine(txPin));
  shch_handler #(.BIT_CYCLES(BITC), .MODEL_ID(MODEL), .FW_ID(FW)) u_dut (
    .clk(clk), .sys_rst(sysRst), .rxPin(rxPin), .txPin(txPin), .locationNumber(6'h05),
    .recData(recData), .recValid(recValid), .recReady(recReady), .cycleDone(cycleDone),
    .holding(holding), .autoMode(autoMode), .countRun(countRun), .countTimed(countTimed),
    .pumpOn(pumpOn), .sensorOn(sensorOn), .offLine(offLine), .selected(selected),
    .universal(universal));
  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Watchdog, several times the expected run
  initial begin
    #(60000 * 25);
    errCount++;
    summarize();
  end
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmpCount++;
    if (got !== exp) begin
      errCount++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  // Send one command and gather up to n+1 reply bytes
  task cmd(input logic [7:0] c, input int n);
    logic [7:0] b;
    bit ok;
    u_host.sendByte(c);
    rx.delete();
    repeat (n + 1) begin
      u_host.getByte(40, b, ok);
      if (ok) rx.push_back(b);
    end
  endtask : cmd
  // First n reply bytes, first byte most significant
  function automatic logic [31:0] word(input int n);
    logic [31:0] r;
    r = '0;
    for (int k = 0; k < n; k++) r = {r[23:0], (k < rx.size()) ? rx[k] : 8'h00};
    return r;
  endfunction : word
  // Datapath handshake: hold until taken
  task push(input logic [7:0] d);
    @(posedge clk);
    recData <= d;
    recValid <= 1'b1;
    do @(posedge clk); while (recReady !== 1'b1);
    recValid <= 1'b0;
  endtask : push
  task pulseDone();
    @(posedge clk);
    cycleDone <= 1'b1;
    @(posedge clk);
    cycleDone <= 1'b0;
  endtask : pulseDone
  task summarize();
    $display("Counts: %0d compared, %0d failed", cmpCount, errCount);
    if (errCount == 0 && cmpCount > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize
  initial begin
    sysRst = 1'b1;
    recData = 8'h00;
    recValid = 1'b0;
    cycleDone = 1'b0;
    holding = 1'b0;
    errCount = 0;
    cmpCount = 0;
    repeat (16) @(posedge clk);
    sysRst <= 1'b0;
    @(negedge clk);
    chk("reset levels", 7'b1111000, {txPin, recReady, pumpOn, sensorOn, selected, universal,
      offLine});
    cmd(8'h85, 0);
    chk("select", 1, selected);
    $display("Test reset and select done");
    foreach (rows[i]) begin
      cmd(rows[i].c, rows[i].n);
      chk("reply", rows[i].r, word(rows[i].n));
      if (rows[i].n == 0) chk("no reply", 0, rx.size());
      chk("levels", rows[i].lv, {autoMode, countRun, pumpOn});
    end
    $display("Test command table done");
    cmd(8'h64, 0);
    chk("timed", 1, countTimed);
    @(posedge clk);
    holding <= 1'b1;
    cmd(8'h4D, 1);
    chk("hold state", 32'h48, word(1));
    holding <= 1'b0;
    pulseDone();
    @(negedge clk);
    chk("timed end", 0, countRun);
    cmd(8'h45, 6);
    chk("fw id", FW[47:16], word(4));
    chk("fw rev", FW[15:0], {rx[4], rx[5]});
    $display("Test timed, hold and firmware done");
    for (int i = 0; i < 32; i++) push(8'(8'h40 + i));
    @(negedge clk);
    chk("full refuses", 0, recReady);
    pulseDone();
    cmd(8'h44, 2);
    chk("one record", 32'h3031, word(2));
    cmd(8'h41, 32);
    for (int k = 0; k < 32; k++) chk("record char", 8'(8'h40 + k), rx[k]);
    cmd(8'h52, 32);
    chk("resend", 32'h404142, word(3));
    chk("resend length", 32, rx.size());
    cmd(8'h41, 1);
    chk("drained", 32'h23, word(1));
    push(8'h31);
    pulseDone();
    cmd(8'h43, 0);
    cmd(8'h41, 1);
    chk("cleared", 32'h23, word(1));
    $display("Test record buffer done");
    cmd(8'h86, 0);
    chk("deselect", 0, selected);
    cmd(8'h4D, 0);
    chk("silent", 0, rx.size());
    @(posedge clk);
    sysRst <= 1'b1;
    repeat (2) @(posedge clk);
    sysRst <= 1'b0;
    cmd(8'h55, 0);
    chk("universal", 1, universal);
    cmd(8'h4D, 1);
    chk("universal reply", 32'h53, word(1));
    cmd(8'h86, 0);
    chk("cancel", 0, universal);
    cmd(8'h55, 0);
    chk("no re-arm", 0, universal);
    cmd(8'h85, 0);
    cmd(8'h6C, 0);
    chk("offline", 1, offLine);
    cmd(8'h4D, 0);
    chk("offline silent", 0, rx.size());
    $display("Test selection done");
    summarize();
  end
endmodule : shch_handler_tb
`default_nettype wire

// [test/shch_host_model.sv]
// Controlling computer model: sends command bytes, collects reply bytes
`default_nettype none
module shch_host_model #(
  parameter int BIT_CYCLES = 8
) (
  input wire logic clk,
  output var logic rxLine,
  input wire logic txLine
);
  timeunit 1ns;
  timeprecision 1ps;
  // Line idles at mark level between frames
  initial rxLine = 1'b1;
  task sendByte(input logic [7:0] b);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      rxLine <= frame[i];
      repeat (BIT_CYCLES - 1) @(posedge clk);
    end
  endtask : sendByte
  // sample mid-bit, LSB first; stop bit must be high
  task getByte(input int limit, output logic [7:0] b, output bit ok);
    int n;
    ok = 1'b0;
    b = 8'h00;
    n = 0;
    // Bounded wait so silence is seen as no reply
    while (txLine !== 1'b0 && n < limit) begin
      @(posedge clk);
      n++;
    end
    if (txLine === 1'b0) begin
      repeat (BIT_CYCLES / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYCLES) @(posedge clk);
        b[i] = txLine;
      end
      repeat (BIT_CYCLES) @(posedge clk);
      ok = (txLine === 1'b1);
    end
  endtask : getByte
endmodule : shch_host_model
`default_nettype wire
